/* File: common/lcfd_pkg.sv */
// Constants and types for the LED channel fault diagnostics block
// Function
// - Short and open detection kept separately for every channel.
// - Short monitor counts only during the channel on-time.
// - Short fault after sense stays low past deglitch; timer restarts on release.
// - Short fault turns the channel off and retries until the short is gone.
// - Short retry repeats pull-up pulse for on time, then waits off time.
// - In either retry state the channel dimming input is ignored.
// - Open fault after drain-sense difference stays low past deglitch; resets on release.
// - Open fault turns that channel off, pulls the fail line low and retries until removed.
// - Open retry repeats pull-up pulse for on time, then waits off time.
// - Open detection results ignored while open diagnostic enable is low.
// - Fail line weakly high normally, pulled strongly low on any fault.
// - Fail line low shuts all outputs and charge pump; faulty channels keep retrying.
// - Over-temperature turns everything off and pulls fail line low until cooled.
// - Fail line held high externally: only faulty channel off, pump keeps running.
// - Fail line shared by up to fifteen controllers, all shut off together.
// - Fail line pulled low externally keeps all channel outputs disabled.
package lcfd_pkg;
    localparam int LCFD_CHANNELS       = 3;
    localparam int LCFD_MAX_PEERS      = 15;
    localparam int LCFD_CLK_NS         = 5;
    localparam int LCFD_SHORT_DEG_NS   = 10000;
    localparam int LCFD_OPEN_DEG_NS    = 10000;
    localparam int LCFD_RETRY_ON_NS    = 2000;
    localparam int LCFD_RETRY_OFF_NS   = 20000;
    localparam int LCFD_SHORT_DEG_CYC  = (LCFD_SHORT_DEG_NS + LCFD_CLK_NS - 1) / LCFD_CLK_NS;
    localparam int LCFD_OPEN_DEG_CYC   = (LCFD_OPEN_DEG_NS + LCFD_CLK_NS - 1) / LCFD_CLK_NS;
    localparam int LCFD_RETRY_ON_CYC   = (LCFD_RETRY_ON_NS + LCFD_CLK_NS - 1) / LCFD_CLK_NS;
    localparam int LCFD_RETRY_OFF_CYC  = (LCFD_RETRY_OFF_NS + LCFD_CLK_NS - 1) / LCFD_CLK_NS;
    localparam int LCFD_CNT_W          = 16;

    typedef enum logic [1:0] {
        LCFD_NORMAL,
        LCFD_SHORT_RETRY,
        LCFD_OPEN_RETRY
    } lcfd_mode_t;

    typedef enum logic {
        LCFD_PULSE,
        LCFD_WAIT
    } lcfd_phase_t;
endpackage

/* File: logic/lcfd_channel.sv */
// One channel: deglitch, retry sequencing and channel enable
module lcfd_channel
    import lcfd_pkg::*;
#(
    parameter int SHORT_DEG_CYC = LCFD_SHORT_DEG_CYC,
    parameter int OPEN_DEG_CYC  = LCFD_OPEN_DEG_CYC,
    parameter int RETRY_ON_CYC  = LCFD_RETRY_ON_CYC,
    parameter int RETRY_OFF_CYC = LCFD_RETRY_OFF_CYC
)(
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic clk_en_in,
    input  wire logic dim_in,
    input  wire logic short_low_in,
    input  wire logic open_low_in,
    input  wire logic diag_en_in,
    input  wire logic global_off_in,
    output logic      drive_out,
    output logic      retry_pulse_out,
    output logic      fault_out
);
    typedef struct packed {
        lcfd_mode_t              mode;
        lcfd_phase_t             phase;
        logic [LCFD_CNT_W-1:0]   sg_cnt;
        logic [LCFD_CNT_W-1:0]   op_cnt;
        logic [LCFD_CNT_W-1:0]   rt_cnt;
        logic                    drive;
        logic                    pulse;
        logic                    fault;
    } lcfd_ch_t;

    lcfd_ch_t st_reg;
    lcfd_ch_t st_next;

    function automatic logic [LCFD_CNT_W-1:0] bump(input logic [LCFD_CNT_W-1:0] c);
        bump = (c == {LCFD_CNT_W{1'b1}}) ? c : c + LCFD_CNT_W'(1);
    endfunction

    always_comb
    begin
        st_next = st_reg;
        case (st_reg.mode)
            LCFD_NORMAL:
            begin
                // Timers restart as soon as the comparator releases
                st_next.sg_cnt = (dim_in && short_low_in)
                                 ? bump(st_reg.sg_cnt) : '0;
                st_next.op_cnt = (dim_in && open_low_in && diag_en_in)
                                 ? bump(st_reg.op_cnt) : '0;
                st_next.rt_cnt = '0;
                st_next.phase  = LCFD_PULSE;
                if (st_reg.sg_cnt >= LCFD_CNT_W'(SHORT_DEG_CYC))
                begin
                    st_next.mode   = LCFD_SHORT_RETRY;
                    st_next.sg_cnt = '0;
                end
                else if (diag_en_in && st_reg.op_cnt >= LCFD_CNT_W'(OPEN_DEG_CYC))
                begin
                    st_next.mode   = LCFD_OPEN_RETRY;
                    st_next.op_cnt = '0;
                end
            end
            default:
            begin
                // Dimming input not looked at here; pulses free-run
                // Deglitch restarts from zero after a retry, no stale count
                st_next.sg_cnt = '0;
                st_next.op_cnt = '0;
                st_next.rt_cnt = bump(st_reg.rt_cnt);
                if (st_reg.phase == LCFD_PULSE)
                begin
                    if (st_reg.rt_cnt >= LCFD_CNT_W'(RETRY_ON_CYC - 1))
                    begin
                        st_next.rt_cnt = '0;
                        st_next.phase  = LCFD_WAIT;
                        // Fault judged at the end of the pulse, comparator settled
                        if (st_reg.mode == LCFD_SHORT_RETRY ? !short_low_in
                            : (!open_low_in || !diag_en_in))
                            st_next.mode = LCFD_NORMAL;
                    end
                end
                else if (st_reg.rt_cnt >= LCFD_CNT_W'(RETRY_OFF_CYC - 1))
                begin
                    st_next.rt_cnt = '0;
                    st_next.phase  = LCFD_PULSE;
                end
            end
        endcase
        st_next.drive = (st_next.mode == LCFD_NORMAL) && dim_in && !global_off_in;
        st_next.pulse = (st_next.mode != LCFD_NORMAL) && (st_next.phase == LCFD_PULSE);
        st_next.fault = (st_next.mode != LCFD_NORMAL);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            st_reg <= '{mode: LCFD_NORMAL, phase: LCFD_PULSE, default: '0};
        else if (clk_en_in)
            st_reg <= st_next;
    end

    assign drive_out       = st_reg.drive;
    assign retry_pulse_out = st_reg.pulse;
    assign fault_out       = st_reg.fault;

    chk_drive_off_fault: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        fault_out |-> !drive_out) else $error("channel driven during fault");
    chk_short_deglitch: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(st_reg.mode == LCFD_SHORT_RETRY)
        |-> $past(st_reg.sg_cnt) >= LCFD_CNT_W'(SHORT_DEG_CYC))
        else $error("short fault before deglitch");
    chk_diag_gates_open: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        clk_en_in && !diag_en_in && st_reg.mode == LCFD_NORMAL
        |=> st_reg.mode != LCFD_OPEN_RETRY)
        else $error("open fault while diagnostics off");
endmodule

/* File: logic/lcfd_top.sv */
// Top: pin synchronisers, thermal and fail-line control, three channels
module lcfd_top
    import lcfd_pkg::*;
#(
    parameter int CHANNELS      = LCFD_CHANNELS,
    parameter int SHORT_DEG_CYC = LCFD_SHORT_DEG_CYC,
    parameter int OPEN_DEG_CYC  = LCFD_OPEN_DEG_CYC,
    parameter int RETRY_ON_CYC  = LCFD_RETRY_ON_CYC,
    parameter int RETRY_OFF_CYC = LCFD_RETRY_OFF_CYC
)(
    input  wire logic                ref_clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                clk_en_in,
    input  wire logic [CHANNELS-1:0] channel_dim_input_in,
    input  wire logic [CHANNELS-1:0] short_below_in,
    input  wire logic [CHANNELS-1:0] open_below_in,
    input  wire logic                open_diag_enable_in,
    input  wire logic                thermal_over_in,
    input  wire logic                fail_n_in,
    output logic                     fail_n_out,
    output logic                     fail_n_oe_n_out,
    output logic                     fail_weak_pullup_out,
    output logic                     charge_pump_en_out,
    output logic                     low_power_out,
    output logic [CHANNELS-1:0]      channel_enable_out,
    output logic [CHANNELS-1:0]      retry_pullup_out,
    output logic [CHANNELS-1:0]      channel_fault_out
);
    localparam int NIN = 3 * CHANNELS + 3;
    // Fail line idles high; its sync stages start there so no false low follows reset
    localparam logic [NIN-1:0] PIN_IDLE = {1'b1, {(NIN-1){1'b0}}};

    typedef struct packed {
        logic [NIN-1:0] s1;
        logic [NIN-1:0] s2;
        logic [NIN-1:0] s3;
        logic [NIN-1:0] val;
        logic           hot;
        logic           pd;
        logic           pump;
        logic           lowp;
        logic           alloff;
    } lcfd_top_t;

    lcfd_top_t st_reg;
    lcfd_top_t st_next;

    logic [NIN-1:0]      raw;
    logic [CHANNELS-1:0] ch_fault;
    logic [CHANNELS-1:0] ch_drive;
    logic [CHANNELS-1:0] ch_pulse;
    logic                any_fault;
    logic                line_low;
    logic                ext_low;

    assign raw = {fail_n_in, thermal_over_in, open_diag_enable_in,
                  open_below_in, short_below_in, channel_dim_input_in};

    // Filtered pin levels, taken only once stages two and three agree
    assign any_fault = (|ch_fault) || st_reg.hot;
    assign line_low  = !st_reg.val[NIN-1];
    // Line low with nothing of ours asserting: some peer pulled it
    assign ext_low   = line_low && !any_fault;

    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < NIN; i++)
            if (st_reg.s2[i] == st_reg.s3[i])
                st_next.val[i] = st_reg.s3[i];
        // Hysteresis lives in the comparator; we follow its output
        st_next.hot    = st_reg.val[NIN-2];
        st_next.pd     = any_fault;
        // Line high despite our pull-down: all-fail disabled, local off only
        st_next.alloff = line_low || st_reg.hot;
        st_next.pump   = !st_next.alloff;
        st_next.lowp   = st_next.alloff;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            st_reg <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, val: PIN_IDLE,
                        pump: 1'b1, default: '0};
        else if (clk_en_in)
            st_reg <= st_next;
    end

    for (genvar c = 0; c < CHANNELS; c++)
    begin : g_ch
        lcfd_channel #(
            .SHORT_DEG_CYC (SHORT_DEG_CYC),
            .OPEN_DEG_CYC  (OPEN_DEG_CYC),
            .RETRY_ON_CYC  (RETRY_ON_CYC),
            .RETRY_OFF_CYC (RETRY_OFF_CYC)
        ) u_ch (
            .ref_clk_in      (ref_clk_in),
            .rst_n_in        (rst_n_in),
            .clk_en_in       (clk_en_in),
            .dim_in          (st_reg.val[c]),
            .short_low_in    (st_reg.val[CHANNELS + c]),
            .open_low_in     (st_reg.val[2*CHANNELS + c]),
            .diag_en_in      (st_reg.val[NIN-3]),
            .global_off_in   (st_reg.alloff),
            .drive_out       (ch_drive[c]),
            .retry_pulse_out (ch_pulse[c]),
            .fault_out       (ch_fault[c])
        );
    end

    assign fail_n_out           = 1'b0;
    assign fail_n_oe_n_out      = !st_reg.pd;
    assign fail_weak_pullup_out = !st_reg.pd;
    assign charge_pump_en_out   = st_reg.pump;
    assign low_power_out        = st_reg.lowp;
    assign channel_enable_out   = ch_drive;
    assign retry_pullup_out     = ch_pulse;
    assign channel_fault_out    = ch_fault;

    chk_fail_pulldown: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        clk_en_in && any_fault |=> !fail_n_oe_n_out) else $error("fault without pull-down");
    chk_ext_low_off: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        clk_en_in && ext_low ##1 clk_en_in |=> channel_enable_out == '0)
        else $error("output on while line low");
    chk_hot_pump_off: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        clk_en_in && st_reg.hot |=> !charge_pump_en_out) else $error("pump on while hot");
endmodule

/* File: testbench/lcfd_far_side.sv */
// Far side model: LED strings and the shared open-drain fail line
module lcfd_far_side
(
    input  wire logic       dut_oe_n_in,
    input  wire logic       peer_pull_in,
    input  wire logic       ext_up_in,
    input  wire logic [2:0] shorted_in,
    input  wire logic [2:0] opened_in,
    input  wire logic [2:0] dropout_in,
    output logic            fail_n_out,
    output logic [2:0]      short_below_out,
    output logic [2:0]      open_below_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wired-and of all pull-downs; a strong external pull-up wins over them
    assign fail_n_out = ext_up_in | ~(~dut_oe_n_in | peer_pull_in);
    // A shorted string holds the sense node low even during retry pulses
    assign short_below_out = shorted_in;
    // Dropout looks like an open string, so the bench keeps the enable low then
    assign open_below_out = opened_in | dropout_in;
endmodule

/* File: testbench/lcfd_top_tb.sv */
// Self-checking bench for the fault diagnostics top
module lcfd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lcfd_pkg::*;
    localparam int DEG = 8;
    localparam int ON  = 4;
    localparam int OFF = 10;
    logic       clk = 0, rst_n = 0, diag = 0, hot = 0, peer = 0, ext_up = 0;
    logic [2:0] dim = 3'h7, shorted = 3'h0, opened = 3'h0, drop = 3'h0;
    logic [2:0] sb, ob, en, pu, flt;
    logic       fail_n, oe_n, wpu, pump, lowp, fdat;
    int         err_total = 0, n_tests = 0, cyc = 0;

    lcfd_top #(.SHORT_DEG_CYC(DEG), .OPEN_DEG_CYC(DEG), .RETRY_ON_CYC(ON),
        .RETRY_OFF_CYC(OFF)) i_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
        .channel_dim_input_in(dim), .short_below_in(sb), .open_below_in(ob),
        .open_diag_enable_in(diag), .thermal_over_in(hot), .fail_n_in(fail_n),
        .fail_n_out(fdat), .fail_n_oe_n_out(oe_n), .fail_weak_pullup_out(wpu),
        .charge_pump_en_out(pump), .low_power_out(lowp), .channel_enable_out(en),
        .retry_pullup_out(pu), .channel_fault_out(flt));
    lcfd_far_side i_far (.dut_oe_n_in(oe_n), .peer_pull_in(peer), .ext_up_in(ext_up),
        .shorted_in(shorted), .opened_in(opened), .dropout_in(drop), .fail_n_out(fail_n),
        .short_below_out(sb), .open_below_out(ob));

    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // Generous ceiling: every scenario ends well inside a few hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_fault(int ch, logic v);
        for (int i = 0; i < 200 && flt[ch] !== v; i++) tick(1);
        chk("channel_fault_out", {7'h0, v}, {7'h0, flt[ch]});
    endtask
    // Finds a retry pulse start, then checks its length, the gap and the next pulse
    task automatic see_pulse(int ch);
        for (int i = 0; i < ON + OFF + 4 && pu[ch] !== 1'b1; i++) tick(1);
        chk("retry_pullup_out on", 8'h1, {7'h0, pu[ch]});
        tick(ON - 1);
        chk("retry_pullup_out held", 8'h1, {7'h0, pu[ch]});
        tick(1);
        chk("retry_pullup_out off", 8'h0, {7'h0, pu[ch]});
        tick(OFF - 1);
        chk("retry_pullup_out gap", 8'h0, {7'h0, pu[ch]});
        tick(1);
        chk("retry_pullup_out next", 8'h1, {7'h0, pu[ch]});
    endtask
    task automatic t_reset();
        chk("fail_n_oe_n_out", 8'h1, {7'h0, oe_n});
        chk("fail_weak_pullup_out", 8'h1, {7'h0, wpu});
        chk("fail_n_out", 8'h0, {7'h0, fdat});
        chk("charge_pump_en_out", 8'h1, {7'h0, pump});
        tick(2);
        // A false line-low after reset would stop the pump here
        chk("charge_pump_en_out settled", 8'h1, {7'h0, pump});
        chk("low_power_out", 8'h0, {7'h0, lowp});
        tick(6);
        chk("channel_enable_out", 8'h7, {5'h0, en});
    endtask
    task automatic t_short();
        @(posedge clk) dim <= 3'h6;
        shorted <= 3'h1;
        tick(DEG * 3);
        chk("short while off", 8'h0, {5'h0, flt});
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk) dim <= 3'h7;
            tick(DEG - 3);
            @(posedge clk) shorted <= 3'h0;
            tick(5);
            @(posedge clk) shorted <= 3'h1;
        end
        tick(1);
        chk("short glitches", 8'h0, {5'h0, flt});
        wait_fault(0, 1'b1);
        @(posedge clk) dim <= 3'h6;
        tick(2);
        chk("fail_n_oe_n_out", 8'h0, {7'h0, oe_n});
        chk("fail_weak_pullup_out", 8'h0, {7'h0, wpu});
        tick(6);
        chk("all-fail enables", 8'h0, {5'h0, en});
        chk("all-fail pump", 8'h0, {7'h0, pump});
        chk("all-fail low power", 8'h1, {7'h0, lowp});
        chk("other channels", 8'h1, {5'h0, flt});
        see_pulse(0);
        @(posedge clk) shorted <= 3'h0;
        dim <= 3'h7;
        wait_fault(0, 1'b0);
        tick(10);
        chk("recovered enables", 8'h7, {5'h0, en});
        chk("recovered pump", 8'h1, {7'h0, pump});
        chk("recovered low power", 8'h0, {7'h0, lowp});
    endtask
    task automatic t_open();
        @(posedge clk) ext_up <= 1'b1;
        drop <= 3'h4;
        tick(DEG * 3);
        chk("open while disabled", 8'h0, {5'h0, flt});
        @(posedge clk) drop <= 3'h0;
        opened <= 3'h4;
        diag <= 1'b1;
        wait_fault(2, 1'b1);
        tick(8);
        chk("held-high enables", 8'h3, {5'h0, en});
        chk("held-high pump", 8'h1, {7'h0, pump});
        see_pulse(2);
        @(posedge clk) opened <= 3'h0;
        wait_fault(2, 1'b0);
        @(posedge clk) ext_up <= 1'b0;
        tick(10);
        chk("open recovered", 8'h7, {5'h0, en});
    endtask
    task automatic t_line();
        @(posedge clk) peer <= 1'b1;
        tick(8);
        chk("peer pulled enables", 8'h0, {5'h0, en});
        chk("peer pulled pump", 8'h0, {7'h0, pump});
        @(posedge clk) peer <= 1'b0;
        hot <= 1'b1;
        tick(8);
        chk("hot oe_n", 8'h0, {7'h0, oe_n});
        chk("hot enables", 8'h0, {5'h0, en});
        chk("hot pump", 8'h0, {7'h0, pump});
        @(posedge clk) hot <= 1'b0;
        tick(14);
        chk("cooled enables", 8'h7, {5'h0, en});
        chk("cooled low power", 8'h0, {7'h0, lowp});
        chk("cooled oe_n", 8'h1, {7'h0, oe_n});
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        tick(4);
        @(posedge clk) rst_n <= 1'b1;
        tick(1);
        t_reset();
        t_short();
        t_open();
        t_line();
        tally_and_finish();
    end
endmodule
